// File: design/cda_flags.sv
// Flag evaluation of a 36-bit compare or decrement result
`timescale 1ns/10ps
`default_nettype none
module cda_flags
  import cda_pkg::*;
(
  input  wire logic [35:0] res,       // Result
  input  wire logic        carry,     // Borrow out of bit 35
  input  wire logic        ovf,       // Signed overflow
  input  wire logic        dec_word,  // Word decrement zero test
  input  wire logic        pmove,     // Parallel move present
  input  wire logic        pm_limit,  // Limiting in parallel move
  input  wire logic        pm_size,   // Size status from parallel move
  input  wire logic        sz_old,    // Previous size flag
  output logic      [7:0]  condition_code_byte        // New flag byte
);

  // ---------------------------------------------------------------------------
  // Combinational flag set
  // ---------------------------------------------------------------------------
  always_comb begin
    condition_code_byte = 8'h00;
    condition_code_byte[CDA_CC_SZ] = pmove ? (sz_old | pm_size) : sz_old;
    condition_code_byte[CDA_CC_L]  = (pmove & pm_limit) | ovf;
    condition_code_byte[CDA_CC_E]  = ~((&res[35:31]) | ~(|res[35:31]));
    // unnormalized when bits 31 and 30 agree
    condition_code_byte[CDA_CC_U]  = ~(res[31] ^ res[30]);
    condition_code_byte[CDA_CC_N]  = res[35];
    // zero test, full or upper 20 bits
    condition_code_byte[CDA_CC_Z]  = dec_word ? ~(|res[35:16]) : ~(|res);
    condition_code_byte[CDA_CC_V]  = ovf;
    condition_code_byte[CDA_CC_C]  = carry;
  end

endmodule : cda_flags
`default_nettype wire

// File: design/cda_timer.sv
// Down counter that holds an instruction for its cycle count
`timescale 1ns/10ps
`default_nettype none
module cda_timer (
  input  wire logic       clk_sys, // System clock
  input  wire logic       rst,     // Async reset, active high
  input  wire logic       load,    // Start a count
  input  wire logic [3:0] cycles,  // Cycles to hold
  output logic            busy,    // Counting
  output logic            done     // Last cycle pulse
);

  logic [3:0] cnt_q; // Remaining cycles

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else if (load) begin
      cnt_q <= cycles;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  assign busy = (cnt_q != 4'h0);
  assign done = (cnt_q == 4'h1);

endmodule : cda_timer
`default_nettype wire

// File: design/cda_unit.sv
// Compare, word decrement and debug entry unit with APB registers
`timescale 1ns/10ps
`default_nettype none
module cda_unit
  import cda_pkg::*;
(
  input  wire logic        clk_sys,     // System clock
  input  wire logic        rst,         // Async reset, active high
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB enable
  input  wire logic        pwrite,      // APB direction
  input  wire logic [7:0]  paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error
  output logic             debug_state, // In debug processing state
  output logic             op_busy      // Instruction in progress
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [11:0] ctrl_q;     // Latched command fields
  logic [15:0] src_q;      // Source word or immediate
  logic [35:0] dst_q;      // Destination accumulator or register
  logic [15:0] mem_q;      // Memory operand word
  logic [7:0]  ccr_q;      // condition_code_byte
  logic [7:0]  mode_q;     // mode_byte
  logic [35:0] res_q;      // Last difference (for visibility)
  logic [1:0]  words_q;    // Program words of last instruction
  logic        dis_q;      // debug_entry_disable_bit
  logic        nop_q;      // Debug fell through as two no-op steps
  logic        dbg_q;      // Debug state
  logic        pend_q;     // Result commit pending
  logic [3:0]  cyc_d;      // Cycles for the started op
  logic [1:0]  words_d;    // Words for the started op
  logic        go;         // Start strobe
  logic        busy;       // Timer running
  logic        done;       // Timer last cycle
  logic        wr_acc;     // APB write access
  logic        rd_acc;     // APB read access

  cda_op_t op;
  cda_am_t am;
  assign op = cda_op_t'(ctrl_q[CDA_CTRL_OP_LSB +: 2]);
  assign am = cda_am_t'(ctrl_q[CDA_CTRL_AM_LSB +: 3]);

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  // Commands are ignored while an op runs; no queue is kept
  assign go = wr_acc & (paddr == CDA_OFF_CTRL) & pwdata[CDA_CTRL_GO_BIT]
              & ~busy & ~dbg_q;

  // ---------------------------------------------------------------------------
  // Operand formation and arithmetic
  // ---------------------------------------------------------------------------
  logic [15:0] word_s;   // Source word chosen by mode
  logic [35:0] opnd;     // 36-bit subtrahend
  logic [36:0] diff;     // Compare difference with borrow
  logic [16:0] wdec;     // Word decrement with borrow
  logic [15:0] wsrc;     // Word being decremented
  logic [35:0] res;      // Result for flags
  logic        carry;
  logic        ovf;
  logic [7:0]  ccr_new;
  logic        is_acc;

  assign is_acc = ctrl_q[CDA_CTRL_ACC_BIT];

  always_comb begin
    word_s = src_q;
    if (am == CDA_AM_SP || am == CDA_AM_AA || am == CDA_AM_ABS) begin
      word_s = mem_q;
    end else if (am == CDA_AM_IMS) begin
      word_s = {11'h000, src_q[4:0]};
    end
  end

  // sign extend then append sixteen zeros
  assign opnd = {{4{word_s[15]}}, word_s, 16'h0000};
  assign diff = {1'b0, dst_q} - {1'b0, opnd};
  // word source: upper word of acc, register, or memory
  assign wsrc = (am != CDA_AM_REG) ? mem_q :
                (is_acc ? dst_q[31:16] : dst_q[15:0]);
  assign wdec = {1'b0, wsrc} - 17'h00001;

  always_comb begin
    res   = diff[35:0];
    carry = diff[36];
    ovf   = (dst_q[35] ^ opnd[35]) & (dst_q[35] ^ diff[35]);
    if (op == CDA_OP_WORD_DECREMENT_OP) begin
      // flags from the 16-bit result placed in the upper word
      res   = {{4{wdec[15]}}, wdec[15:0], 16'h0000};
      carry = wdec[16];
      ovf   = wsrc[15] & ~wdec[15];
    end
  end

  cda_flags u_flags (
    .res      (res),
    .carry    (carry),
    .ovf      (ovf),
    .dec_word (op == CDA_OP_WORD_DECREMENT_OP),
    .pmove    (ctrl_q[CDA_CTRL_PM_BIT]),
    .pm_limit (ctrl_q[CDA_CTRL_LIM_BIT]),
    .pm_size  (ctrl_q[CDA_CTRL_SZ_BIT]),
    .sz_old   (ccr_q[CDA_CC_SZ]),
    .condition_code_byte      (ccr_new)
  );

  // ---------------------------------------------------------------------------
  // Cycle and word count per form
  // ---------------------------------------------------------------------------
  always_comb begin
    cyc_d   = CDA_CYC_REG;
    words_d = CDA_WORDS_ONE;
    case (cda_op_t'(pwdata[CDA_CTRL_OP_LSB +: 2]))
      CDA_OP_CMP: begin
        case (cda_am_t'(pwdata[CDA_CTRL_AM_LSB +: 3]))
          CDA_AM_SP:  cyc_d = CDA_CYC_CMP_SP;
          CDA_AM_AA:  cyc_d = CDA_CYC_CMP_AA;
          CDA_AM_ABS: begin
            cyc_d   = CDA_CYC_CMP_ABS;
            words_d = CDA_WORDS_TWO;
          end
          CDA_AM_IMS: cyc_d = CDA_CYC_CMP_IMS;
          CDA_AM_IML: begin
            cyc_d   = CDA_CYC_CMP_IML;
            words_d = CDA_WORDS_TWO;
          end
          default:    cyc_d = CDA_CYC_REG;
        endcase
      end
      CDA_OP_WORD_DECREMENT_OP: begin
        case (cda_am_t'(pwdata[CDA_CTRL_AM_LSB +: 3]))
          CDA_AM_SP:  cyc_d = CDA_CYC_DEC_SP;
          CDA_AM_AA:  cyc_d = CDA_CYC_DEC_AA;
          CDA_AM_ABS: begin
            cyc_d   = CDA_CYC_DEC_ABS;
            words_d = CDA_WORDS_TWO;
          end
          default:    cyc_d = CDA_CYC_REG;
        endcase
      end
      CDA_OP_DEBUG: cyc_d = CDA_CYC_DEBUG;
      default:      cyc_d = CDA_CYC_PMOVE;
    endcase
    // a parallel move with register addressing collapses to one word, one cycle
    if (pwdata[CDA_CTRL_PM_BIT] &&
        pwdata[CDA_CTRL_AM_LSB +: 3] == 3'h0) begin
      cyc_d   = CDA_CYC_PMOVE;
      words_d = CDA_WORDS_ONE;
    end
  end

  cda_timer u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (go),
    .cycles  (cyc_d),
    .busy    (busy),
    .done    (done)
  );

  // ---------------------------------------------------------------------------
  // Command latch
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q  <= 12'h000;
      words_q <= 2'h0;
    end else if (go) begin
      ctrl_q  <= pwdata[11:0];
      words_q <= words_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Operand registers; software writes, decrement commits
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_q <= 16'h0000;
      dst_q <= CDA_RST_ACC;
      mem_q <= 16'h0000;
    end else if (done && op == CDA_OP_WORD_DECREMENT_OP) begin
      if (am != CDA_AM_REG) begin
        mem_q <= wdec[15:0];
      end else if (is_acc) begin
        // lower word kept, extension and upper word updated
        dst_q <= {{4{wdec[15]}}, wdec[15:0], dst_q[15:0]};
      end else begin
        dst_q <= {20'h00000, wdec[15:0]};
      end
    end else if (wr_acc && !busy) begin
      if (paddr == CDA_OFF_SRC) begin
        src_q <= pwdata[15:0];
      end else if (paddr == CDA_OFF_DST_LO) begin
        dst_q[31:0] <= pwdata;
      end else if (paddr == CDA_OFF_DST_HI) begin
        dst_q[35:32] <= pwdata[3:0];
      end else if (paddr == CDA_OFF_MEM) begin
        mem_q <= pwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Flags and mode byte
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ccr_q  <= CDA_RST_CCR;
      mode_q <= CDA_RST_MODE;
      res_q  <= CDA_RST_ACC;
    end else if (done && (op == CDA_OP_CMP || op == CDA_OP_WORD_DECREMENT_OP)) begin
      ccr_q <= ccr_new;
      res_q <= res;
    end else if (wr_acc && !busy && paddr == CDA_OFF_CCR) begin
      ccr_q  <= pwdata[7:0];
      mode_q <= pwdata[15:8];
    end
  end

  // ---------------------------------------------------------------------------
  // Debug entry
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dis_q <= 1'b0;
      dbg_q <= 1'b0;
      nop_q <= 1'b0;
    end else begin
      if (wr_acc && paddr == CDA_OFF_DBGCTL) begin
        dis_q <= pwdata[CDA_DBG_DIS_BIT];
        // Writing bit 1 releases the debug state
        if (pwdata[1]) begin
          dbg_q <= 1'b0;
        end
      end
      if (done && op == CDA_OP_DEBUG) begin
        // enter unless disabled; else just two idle steps
        dbg_q <= ~dis_q;
        nop_q <= dis_q;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped address
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == CDA_OFF_CTRL) begin
          prdata <= {20'h00000, ctrl_q};
        end else if (paddr == CDA_OFF_SRC) begin
          prdata <= {16'h0000, src_q};
        end else if (paddr == CDA_OFF_DST_LO) begin
          prdata <= dst_q[31:0];
        end else if (paddr == CDA_OFF_DST_HI) begin
          prdata <= {28'h0000000, dst_q[35:32]};
        end else if (paddr == CDA_OFF_CCR) begin
          prdata <= {16'h0000, mode_q, ccr_q};
        end else if (paddr == CDA_OFF_STAT) begin
          prdata <= {26'h0000000, words_q, nop_q, dbg_q, pend_q, busy};
        end else if (paddr == CDA_OFF_RES_LO) begin
          prdata <= res_q[31:0];
        end else if (paddr == CDA_OFF_RES_HI) begin
          prdata <= {28'h0000000, res_q[35:32]};
        end else if (paddr == CDA_OFF_DBGCTL) begin
          prdata <= {31'h00000000, dis_q};
        end else if (paddr == CDA_OFF_MEM) begin
          prdata <= {16'h0000, mem_q};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Pending marks an op started and not yet finished
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (go) begin
      pend_q <= 1'b1;
    end else if (done) begin
      pend_q <= 1'b0;
    end
  end

  // Status outputs from flip-flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      debug_state <= 1'b0;
      op_busy     <= 1'b0;
    end else begin
      debug_state <= dbg_q;
      op_busy     <= pend_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_cmp_keeps_dst: assert property (@(posedge clk_sys) disable iff (rst)
    (done && op == CDA_OP_CMP) |=> $stable(dst_q))
    else $error("compare changed destination");
  a_neg_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (done && op != CDA_OP_DEBUG && op != CDA_OP_NONE)
      |=> ccr_q[CDA_CC_N] == $past(res[35]))
    else $error("negative flag wrong");
  a_debug_flags_kept: assert property (@(posedge clk_sys) disable iff (rst)
    (done && op == CDA_OP_DEBUG) |=> $stable(ccr_q))
    else $error("debug altered flags");
  a_debug_entry: assert property (@(posedge clk_sys) disable iff (rst)
    (done && op == CDA_OP_DEBUG && !dis_q) |=> dbg_q)
    else $error("debug state not entered");
  a_reg_cmp_time: assert property (@(posedge clk_sys) disable iff (rst)
    (go && pwdata[1:0] == 2'b00 && pwdata[6:4] == 3'b000
     && !pwdata[CDA_CTRL_PM_BIT]) |=> busy ##1 done)
    else $error("register compare not two cycles");
  a_dec_lsp_kept: assert property (@(posedge clk_sys) disable iff (rst)
    (done && op == CDA_OP_WORD_DECREMENT_OP && is_acc) |=> dst_q[15:0] == $past(dst_q[15:0]))
    else $error("decrement touched lower word");
  a_dec_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (done && op == CDA_OP_WORD_DECREMENT_OP) |=> ccr_q[CDA_CC_Z] == ($past(wdec[15:0]) == 16'h0000))
    else $error("decrement zero flag wrong");
  a_pmove_one: assert property (@(posedge clk_sys) disable iff (rst)
    (go && pwdata[CDA_CTRL_PM_BIT] && pwdata[6:4] == 3'b000) |=> done)
    else $error("parallel move op not one cycle");

endmodule : cda_unit
`default_nettype wire

// File: shared/cda_pkg.sv
// Package: constants, field layout and types of the compare/decrement unit
package cda_pkg;

  // ---------------------------------------------------------------------------
  // Register map (APB byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CDA_OFF_CTRL   = 8'h00; // Command / start
  localparam logic [7:0] CDA_OFF_SRC    = 8'h04; // 16-bit source / immediate
  localparam logic [7:0] CDA_OFF_DST_LO = 8'h08; // Destination bits 31:0
  localparam logic [7:0] CDA_OFF_DST_HI = 8'h0c; // Destination bits 35:32
  localparam logic [7:0] CDA_OFF_CCR    = 8'h10; // Mode byte and flag byte
  localparam logic [7:0] CDA_OFF_STAT   = 8'h14; // Busy, debug state
  localparam logic [7:0] CDA_OFF_RES_LO = 8'h18; // Result bits 31:0
  localparam logic [7:0] CDA_OFF_RES_HI = 8'h1c; // Result bits 35:32
  localparam logic [7:0] CDA_OFF_DBGCTL = 8'h20; // Debug port control
  localparam logic [7:0] CDA_OFF_MEM    = 8'h24; // Memory operand word

  // ---------------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------------
  localparam int CDA_CTRL_OP_LSB  = 0;  // Opcode, 2 bits
  localparam int CDA_CTRL_AM_LSB  = 4;  // Addressing mode, 3 bits
  localparam int CDA_CTRL_ACC_BIT = 8;  // Destination is 36-bit accumulator
  localparam int CDA_CTRL_PM_BIT  = 9;  // Parallel move accompanies op
  localparam int CDA_CTRL_LIM_BIT = 10; // Limiting seen in parallel move
  localparam int CDA_CTRL_SZ_BIT  = 11; // Size status from parallel move
  localparam int CDA_CTRL_GO_BIT  = 31; // Start strobe (write only)

  // Condition-code byte positions
  localparam int CDA_CC_C  = 0;
  localparam int CDA_CC_V  = 1;
  localparam int CDA_CC_Z  = 2;
  localparam int CDA_CC_N  = 3;
  localparam int CDA_CC_U  = 4;
  localparam int CDA_CC_E  = 5;
  localparam int CDA_CC_L  = 6;
  localparam int CDA_CC_SZ = 7;

  // Debug port control: entry disable bit position
  localparam int CDA_DBG_DIS_BIT = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  CDA_RST_CCR  = 8'h00;
  localparam logic [7:0]  CDA_RST_MODE = 8'h00;
  localparam logic [35:0] CDA_RST_ACC  = 36'h0_0000_0000;

  // ---------------------------------------------------------------------------
  // Cycle counts per instruction form
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CDA_CYC_PMOVE    = 4'h1;
  localparam logic [3:0] CDA_CYC_REG      = 4'h2;
  localparam logic [3:0] CDA_CYC_CMP_SP   = 4'h6;
  localparam logic [3:0] CDA_CYC_CMP_AA   = 4'h4;
  localparam logic [3:0] CDA_CYC_CMP_ABS  = 4'h6;
  localparam logic [3:0] CDA_CYC_CMP_IMS  = 4'h4;
  localparam logic [3:0] CDA_CYC_CMP_IML  = 4'h6;
  localparam logic [3:0] CDA_CYC_DEC_SP   = 4'h8;
  localparam logic [3:0] CDA_CYC_DEC_AA   = 4'h6;
  localparam logic [3:0] CDA_CYC_DEC_ABS  = 4'h8;
  localparam logic [3:0] CDA_CYC_DEBUG    = 4'h4;
  localparam logic [1:0] CDA_WORDS_ONE    = 2'h1;
  localparam logic [1:0] CDA_WORDS_TWO    = 2'h2;
  localparam logic [4:0] CDA_IMM_SHORT_MAX = 5'h1f;

  // ---------------------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CDA_OP_CMP   = 2'b00, // compare_op
    CDA_OP_WORD_DECREMENT_OP  = 2'b01, // word_decrement_op
    CDA_OP_DEBUG = 2'b10,
    CDA_OP_NONE  = 2'b11
  } cda_op_t;

  typedef enum logic [2:0] {
    CDA_AM_REG  = 3'b000, // Register to register
    CDA_AM_SP   = 3'b001, // Stack relative memory
    CDA_AM_AA   = 3'b010, // 6-bit short absolute
    CDA_AM_ABS  = 3'b011, // Full absolute address
    CDA_AM_IMS  = 3'b100, // Unsigned 0..31 immediate
    CDA_AM_IML  = 3'b101  // Signed 16-bit immediate
  } cda_am_t;

endpackage : cda_pkg

// File: verif/cda_unit_bench.sv
// Self-checking bench of the compare/decrement unit over APB
`timescale 1ns/10ps
`default_nettype none
module cda_unit_bench;
  import cda_pkg::*;
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic        clk_sys, rst, psel, penable, pwrite; // Bench driven
  logic        pready, pslverr, debug_state, op_busy; // Seen
  logic        rd_err;                                 // Error of last transfer
  logic [7:0]  paddr;                                  // Byte address
  logic [31:0] pwdata, prdata, rd;                     // Data words
  int          err_total, n_checks;                    // Verdict counts
  int          cyc = 0;                                // Hang guard

  cda_unit u_cda_unit (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .debug_state, .op_busy);

  // Free running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard: the whole run needs far fewer cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  // Start an operation, then poll busy with a bounded count
  task automatic run(input logic [31:0] ctl);
    apb(1'b1, CDA_OFF_CTRL, ctl | 32'h8000_0000);
    repeat (20) begin
      apb(1'b0, CDA_OFF_STAT, 32'h0);
      if (rd[0] === 1'b0) break;
    end
  endtask : run

  task automatic ld(input logic [35:0] dst, input logic [15:0] src);
    apb(1'b1, CDA_OFF_DST_LO, dst[31:0]);
    apb(1'b1, CDA_OFF_DST_HI, {28'h0, dst[35:32]});
    apb(1'b1, CDA_OFF_SRC, {16'h0, src});
    apb(1'b1, CDA_OFF_MEM, {16'h0, src});
  endtask : ld

  task automatic ccr_is(input string nm, input logic [7:0] e);
    apb(1'b0, CDA_OFF_CCR, 32'h0);
    chk(nm, {24'h0, e}, {24'h0, rd[7:0]});
  endtask : ccr_is

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Compare flag table; dst kept, word source sign extended
  task automatic t_cmp;
    logic [35:0] dv[6] = '{36'h0_0020_0000, 36'h0_1234_0000, 36'h0,
      36'h7_ffff_ffff, 36'h0_1234_0000, 36'h0_0020_0000};
    logic [15:0] sv[6] = '{16'h0024, 16'h1234, 16'h8000, 16'h8000,
      16'h1234, 16'h0024};
    logic [11:0] cv[6] = '{12'h100, 12'h100, 12'h100, 12'h100, 12'hf00,
      12'h120};
    // Size flag is sticky: once the move sets it, the last case keeps it
    logic [7:0]  ev[6] = '{8'h19, 8'h14, 8'h21, 8'h6b, 8'hd4, 8'h99};
    for (int i = 0; i < 6; i++) begin
      ld(dv[i], sv[i]);
      // move only modelled by the parallel-move, limit and size command bits
      run({20'h0, cv[i]});
      ccr_is("cmp_ccr", ev[i]);
      apb(1'b0, CDA_OFF_DST_LO, 32'h0);
      chk("cmp_dst", dv[i][31:0], rd);
    end
    $display("compare flags done");
  endtask : t_cmp

  // Word decrement: low word kept, zero on upper twenty bits
  task automatic t_word_decrement_op;
    apb(1'b1, CDA_OFF_CCR, 32'h0);
    ld(36'h0_0001_0033, 16'h0);
    run(32'h101);
    apb(1'b0, CDA_OFF_DST_LO, 32'h0);
    chk("word_decrement_op_res", 32'h0000_0033, rd);
    ccr_is("word_decrement_op_z", 8'h14);
    ld(36'h0_0000_0033, 16'h0);
    run(32'h101);
    ccr_is("word_decrement_op_wrap", 8'h19);
    ld(36'h0, 16'h0005);
    run(32'h021);
    apb(1'b0, CDA_OFF_MEM, 32'h0);
    chk("mem_dec", 32'h0000_0004, {16'h0, rd[15:0]});
    ccr_is("mem_ccr", 8'h10);
    $display("word decrement done");
  endtask : t_word_decrement_op

  // Busy length of every form, debug entry disabled
  task automatic t_cyc;
    logic [11:0] cv[13] = '{12'h100, 12'h110, 12'h120, 12'h130, 12'h140,
      12'h150, 12'h101, 12'h111, 12'h121, 12'h131, 12'h300, 12'h301,
      12'h002};
    logic [3:0] ev[13] = '{CDA_CYC_REG, CDA_CYC_CMP_SP, CDA_CYC_CMP_AA,
      CDA_CYC_CMP_ABS, CDA_CYC_CMP_IMS, CDA_CYC_CMP_IML, CDA_CYC_REG,
      CDA_CYC_DEC_SP, CDA_CYC_DEC_AA, CDA_CYC_DEC_ABS, CDA_CYC_PMOVE,
      CDA_CYC_PMOVE, CDA_CYC_DEBUG};
    int n;
    apb(1'b1, CDA_OFF_DBGCTL, 32'h1);
    for (int i = 0; i < 13; i++) begin
      apb(1'b1, CDA_OFF_CTRL, {20'h0, cv[i]} | 32'h8000_0000);
      n = 0;
      repeat (30) begin
        @(posedge clk_sys);
        if (op_busy === 1'b1) n++;
      end
      chk("op_cycles", {28'h0, ev[i]}, n);
    end
    $display("cycle counts done");
  endtask : t_cyc

  // Debug entry blocked, then taken; flags untouched
  task automatic t_dbg;
    logic [7:0] cc;
    apb(1'b0, CDA_OFF_CCR, 32'h0);
    cc = rd[7:0];
    apb(1'b1, CDA_OFF_DBGCTL, 32'h1);
    run(32'h2);
    chk("dbg_off", 32'h0, {31'h0, debug_state});
    apb(1'b1, CDA_OFF_DBGCTL, 32'h0);
    run(32'h2);
    chk("dbg_on", 32'h1, {31'h0, debug_state});
    ccr_is("dbg_ccr", cc);
    apb(1'b1, CDA_OFF_DBGCTL, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk("dbg_exit", 32'h0, {31'h0, debug_state});
    $display("debug entry done");
  endtask : t_dbg

  // Reset value and an unmapped address
  task automatic t_bus;
    ccr_is("ccr_rst", CDA_RST_CCR);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("unmapped_err", 32'h1, {31'h0, rd_err});
    $display("bus access done");
  endtask : t_bus

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_bus();
    t_cmp();
    t_word_decrement_op();
    t_cyc();
    t_dbg();
    summarize();
  end
endmodule : cda_unit_bench
`default_nettype wire
